//--- design/ats_pkg.sv
/*
 * Constants, register map and state encoding of the accelerator task scheduler.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
//
// Function
// R01: eight tasks, each triggered from 256 sources
// R02: sixteen-bit program counter, 64K reach
// R03: task eight may run as background task
// R04: background runs until accelerator or host stops
// R05: tasks one to seven ranked, preempt background
// R06: background sections can be made uninterruptible
// R07: background mode only when host sets enable
// R08: background start vector from background vector register
// R09: save return address on preempt, restore on resume
// R10: eight shared RAM blocks, program or data
// R11: ADC result readable in completion cycle
// R12: background resumes after foreground work, no trigger
package ats_pkg;
	localparam int ATS_TASKS = 8;
	localparam int ATS_SRC_N = 256;
	localparam int ATS_SEL_W = 8;
	localparam int ATS_PC_W = 16;
	localparam int ATS_TID_W = 3;
	localparam int ATS_RAM_N = 8;
	localparam int ATS_ADC_W = 16;
	localparam int ATS_AW = 8;
	localparam int ATS_DW = 32;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_BG_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TASK_EN = 8'h08;
	localparam logic [7:0] OFS_PENDING = 8'h0C;
	localparam logic [7:0] OFS_BG_VECT = 8'h10;
	localparam logic [7:0] OFS_BG_RET = 8'h14;
	localparam logic [7:0] OFS_PC = 8'h18;
	localparam logic [7:0] OFS_RAM_CFG = 8'h1C;
	localparam logic [7:0] OFS_VECT_BASE = 8'h20;
	localparam logic [7:0] OFS_SEL_BASE = 8'h40;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_BG_EN = 0;
	localparam int BIT_BG_KILL = 1;
	localparam int BIT_SOFT_RST = 2;
	localparam int BIT_ST_RUN = 0;
	localparam int BIT_ST_BG = 1;
	localparam int BIT_ST_SUSP = 2;
	localparam int BIT_ST_NOINT = 3;
	localparam int POS_ST_TASK = 4;
	localparam int POS_RAM_PROG = 8;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_TASK_EN = 8'h00;
	localparam logic [7:0] RST_RAM_SHARED = 8'h00;
	localparam logic [7:0] RST_RAM_PROG = 8'h00;
	localparam logic [15:0] RST_VECT = 16'h0000;
	localparam logic [2:0] BG_TASK = 3'h7;
	typedef enum logic [1:0] {
		ATS_IDLE = 2'b00,
		ATS_DISPATCH = 2'b01,
		ATS_RUN = 2'b10
	} ats_state_t;
endpackage : ats_pkg

//--- design/ats_mem_if.sv
/*
 * Link between the scheduler and its vector store.
 * Assumes both ends share mclk.
 */
interface ats_mem_if #(parameter int AW = 3, parameter int DW = 16);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] a_addr;
	logic [DW-1:0] a_data;
	logic [AW-1:0] b_addr;
	logic [DW-1:0] b_data;
	modport owner (output wr_en, wr_addr, wr_data, a_addr, b_addr, input a_data, b_data);
	modport store (input wr_en, wr_addr, wr_data, a_addr, b_addr, output a_data, b_data);
endinterface : ats_mem_if

//--- design/ats_vec_mem.sv
/*
 * Task vector store: one write port, two registered read ports.
 * Assumes the owner never reads and writes one word in the same cycle for fresh data.
 */
module ats_vec_mem
	import ats_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	ats_mem_if.store mem
);
	logic [15:0] word_reg [DEPTH];
	logic [15:0] a_reg;
	logic [15:0] b_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				word_reg[i] <= RST_VECT;
			end
			a_reg <= RST_VECT;
			b_reg <= RST_VECT;
		end else begin
			if (mem.wr_en) begin
				word_reg[mem.wr_addr] <= mem.wr_data;
			end
			a_reg <= word_reg[mem.a_addr];
			b_reg <= word_reg[mem.b_addr];
		end
	end

	assign mem.a_data = a_reg;
	assign mem.b_data = b_reg;
endmodule : ats_vec_mem

//--- design/ats_trig_sel.sv
/*
 * One task trigger: picks a source by number and pulses on its rising edge.
 * Assumes sources are synchronous to mclk.
 */
module ats_trig_sel
	import ats_pkg::*;
#(
	parameter int SRC_N = ATS_SRC_N
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [SRC_N-1:0] src,
	input wire logic [ATS_SEL_W-1:0] sel,
	output logic hit
);
	logic lvl_reg;
	logic lvl_next;
	logic hit_reg;
	logic hit_next;

	always_comb begin
		lvl_next = src[sel]; // [R01]
		hit_next = lvl_next & ~lvl_reg;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lvl_reg <= 1'b0;
			hit_reg <= 1'b0;
		end else begin
			lvl_reg <= lvl_next;
			hit_reg <= hit_next;
		end
	end

	assign hit = hit_reg;
endmodule : ats_trig_sel

//--- design/ats_sched.sv
/*
 * Task scheduler of the control law accelerator: triggers, priority,
 * background task with preemption, program counter, shared RAM setup and
 * the ADC result path.
 * Assumes the accelerator core reports steps, branches and task ends on
 * one-cycle pulses, and that the host register port follows the plain strobe bus.
 */
module ats_sched
	import ats_pkg::*;
#(
	parameter int TASKS = ATS_TASKS,
	parameter int SRC_N = ATS_SRC_N
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ATS_AW-1:0] reg_addr,
	input wire logic [ATS_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ATS_DW-1:0] reg_rdata,
	input wire logic [SRC_N-1:0] periph_irq,
	input wire logic core_step,
	input wire logic core_branch,
	input wire logic [ATS_PC_W-1:0] core_target,
	input wire logic core_task_end,
	input wire logic core_bg_stop,
	input wire logic core_noint_set,
	input wire logic core_noint_clr,
	input wire logic adc_done,
	input wire logic [ATS_ADC_W-1:0] adc_result,
	input wire logic adc_rd,
	output logic [ATS_ADC_W-1:0] adc_rdata,
	output logic [ATS_PC_W-1:0] accel_program_counter,
	output logic task_start,
	output logic task_active,
	output logic [ATS_TID_W-1:0] task_num,
	output logic bg_running,
	output logic [ATS_RAM_N-1:0] ram_shared,
	output logic [ATS_RAM_N-1:0] ram_prog
);
	// ****************************************
	// State
	// ****************************************
	ats_state_t state_reg, state_next;
	logic [ATS_TID_W-1:0] task_reg, task_next;
	logic [ATS_PC_W-1:0] pc_reg, pc_next;
	logic bg_en_reg, bg_en_next;
	logic bg_act_reg, bg_act_next;
	logic bg_susp_reg, bg_susp_next;
	logic noint_reg, noint_next;
	logic [ATS_PC_W-1:0] bg_vec_reg, bg_vec_next;
	logic [ATS_PC_W-1:0] bg_ret_reg, bg_ret_next;
	logic [TASKS-1:0] pend_reg, pend_next;
	logic [TASKS-1:0] ten_reg, ten_next;
	logic [ATS_RAM_N-1:0] sh_reg, sh_next;
	logic [ATS_RAM_N-1:0] prog_reg, prog_next;
	logic [ATS_SEL_W-1:0] sel_reg [TASKS];
	logic [ATS_SEL_W-1:0] sel_next [TASKS];
	logic start_reg, start_next, active_reg, active_next;
	logic [ATS_DW-1:0] rdata_reg, rdata_next;
	logic rd_vec_reg, rd_vec_next;
	logic [ATS_ADC_W-1:0] adc_hold_reg, adc_hold_next;
	logic [ATS_ADC_W-1:0] adc_out_reg, adc_out_next;

	logic [TASKS-1:0] hit;
	logic [TASKS-1:0] pend_clr;
	logic fg_any;
	logic [ATS_TID_W-1:0] fg_pick;
	logic in_vect;
	logic in_sel;
	logic [ATS_TID_W-1:0] idx;
	logic kill;
	logic soft_rst;

	ats_mem_if #(.AW(ATS_TID_W), .DW(ATS_PC_W)) vmem ();

	ats_vec_mem #(.DEPTH(TASKS)) u_vec (
		.mclk(mclk),
		.rst_n(rst_n),
		.mem(vmem.store)
	);

	// ****************************************
	// Trigger selection, one per task
	// ****************************************
	for (genvar t = 0; t < TASKS; t++) begin : g_trig
		ats_trig_sel #(.SRC_N(SRC_N)) u_trig (
			.mclk(mclk),
			.rst_n(rst_n),
			.src(periph_irq),
			.sel(sel_reg[t]),
			.hit(hit[t])
		); // [R01]
	end

	// ****************************************
	// Register decode
	// ****************************************
	always_comb begin
		in_vect = (reg_addr[7:5] == OFS_VECT_BASE[7:5]);
		in_sel = (reg_addr[7:5] == OFS_SEL_BASE[7:5]);
		idx = reg_addr[4:2];
		kill = reg_wr && reg_addr == OFS_BG_CTRL && reg_wdata[BIT_BG_KILL];
		soft_rst = reg_wr && reg_addr == OFS_BG_CTRL && reg_wdata[BIT_SOFT_RST];
		vmem.wr_en = reg_wr && in_vect;
		vmem.wr_addr = idx;
		vmem.wr_data = reg_wdata[ATS_PC_W-1:0];
		vmem.a_addr = idx;
	end

	always_comb begin
		ten_next = ten_reg;
		sh_next = sh_reg;
		prog_next = prog_reg;
		bg_en_next = bg_en_reg;
		bg_vec_next = bg_vec_reg;
		sel_next = sel_reg;
		if (reg_wr) begin
			unique case (1'b1)
				reg_addr == OFS_BG_CTRL: bg_en_next = reg_wdata[BIT_BG_EN]; // [R07]
				reg_addr == OFS_TASK_EN: ten_next = reg_wdata[TASKS-1:0];
				reg_addr == OFS_BG_VECT: bg_vec_next = reg_wdata[ATS_PC_W-1:0];
				reg_addr == OFS_RAM_CFG: begin
					sh_next = reg_wdata[ATS_RAM_N-1:0]; // [R10]
					prog_next = reg_wdata[POS_RAM_PROG +: ATS_RAM_N]; // [R10]
				end
				in_sel: sel_next[idx] = reg_wdata[ATS_SEL_W-1:0]; // [R01]
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_vec_next = reg_rd && in_vect;
		rdata_next = '0;
		if (reg_rd) begin
			unique case (1'b1)
				reg_addr == OFS_BG_CTRL: rdata_next[BIT_BG_EN] = bg_en_reg;
				reg_addr == OFS_STATUS: begin
					rdata_next[BIT_ST_RUN] = (state_reg == ATS_RUN);
					rdata_next[BIT_ST_BG] = bg_act_reg;
					rdata_next[BIT_ST_SUSP] = bg_susp_reg;
					rdata_next[BIT_ST_NOINT] = noint_reg;
					rdata_next[POS_ST_TASK +: ATS_TID_W] = task_reg;
				end
				reg_addr == OFS_TASK_EN: rdata_next[TASKS-1:0] = ten_reg;
				reg_addr == OFS_PENDING: rdata_next[TASKS-1:0] = pend_reg;
				reg_addr == OFS_BG_VECT: rdata_next[ATS_PC_W-1:0] = bg_vec_reg;
				reg_addr == OFS_BG_RET: rdata_next[ATS_PC_W-1:0] = bg_ret_reg;
				reg_addr == OFS_PC: rdata_next[ATS_PC_W-1:0] = pc_reg;
				reg_addr == OFS_RAM_CFG: begin
					rdata_next[ATS_RAM_N-1:0] = sh_reg;
					rdata_next[POS_RAM_PROG +: ATS_RAM_N] = prog_reg;
				end
				in_sel: rdata_next[ATS_SEL_W-1:0] = sel_reg[idx];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Scheduler
	// ****************************************
	always_comb begin
		fg_any = 1'b0;
		fg_pick = '0;
		for (int t = TASKS - 2; t >= 0; t--) begin
			if (pend_reg[t]) begin
				fg_any = 1'b1;
				fg_pick = ATS_TID_W'(t); // [R05]
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		task_next = task_reg;
		pc_next = pc_reg;
		bg_act_next = bg_act_reg;
		bg_susp_next = bg_susp_reg;
		bg_ret_next = bg_ret_reg;
		noint_next = noint_reg;
		pend_clr = '0;
		start_next = 1'b0;
		vmem.b_addr = fg_pick;
		unique case (state_reg)
			ATS_IDLE: begin
				if (fg_any) begin
					task_next = fg_pick;
					pend_clr[fg_pick] = 1'b1;
					state_next = ATS_DISPATCH;
				end else if (bg_susp_reg) begin
					pc_next = bg_ret_reg; // [R09] [R12]
					task_next = BG_TASK;
					bg_susp_next = 1'b0;
					bg_act_next = 1'b1;
					state_next = ATS_RUN;
				end else if (pend_reg[BG_TASK]) begin
					vmem.b_addr = BG_TASK;
					task_next = BG_TASK;
					pend_clr[BG_TASK] = 1'b1;
					bg_act_next = bg_en_reg; // [R03] [R07]
					noint_next = 1'b0;
					state_next = ATS_DISPATCH;
				end
			end
			ATS_DISPATCH: begin
				if (bg_act_reg && task_reg == BG_TASK) begin
					pc_next = bg_vec_reg; // [R08]
				end else begin
					pc_next = vmem.b_data;
				end
				start_next = 1'b1;
				state_next = ATS_RUN;
			end
			ATS_RUN: begin
				if (core_branch) begin
					pc_next = core_target; // [R02]
				end else if (core_step) begin
					pc_next = pc_reg + 16'h0001; // [R02]
				end
				if (bg_act_reg) begin
					if (core_noint_set) begin
						noint_next = 1'b1; // [R06]
					end else if (core_noint_clr) begin
						noint_next = 1'b0;
					end
					if (core_bg_stop || core_task_end) begin
						bg_act_next = 1'b0; // [R04]
						noint_next = 1'b0;
						state_next = ATS_IDLE;
					end else if (fg_any && !noint_reg) begin
						bg_ret_next = pc_reg; // [R05] [R06] [R09]
						bg_susp_next = 1'b1;
						bg_act_next = 1'b0;
						task_next = fg_pick;
						pend_clr[fg_pick] = 1'b1;
						state_next = ATS_DISPATCH;
					end
				end else if (core_task_end) begin
					state_next = ATS_IDLE;
				end
			end
			default: state_next = ATS_IDLE;
		endcase
		if (kill || !bg_en_reg) begin
			bg_susp_next = 1'b0; // [R04]
			if (bg_act_reg) begin
				bg_act_next = 1'b0;
				noint_next = 1'b0;
				state_next = ATS_IDLE;
			end
		end
		// A trigger landing on the clearing cycle is kept
		pend_next = (pend_reg & ~pend_clr) | (hit & ten_reg); // [R01]
		active_next = (state_next == ATS_RUN);
	end

	// ****************************************
	// ADC result path
	// ****************************************
	always_comb begin
		adc_hold_next = adc_done ? adc_result : adc_hold_reg;
		adc_out_next = adc_out_reg;
		if (adc_rd) begin
			// Forward the fresh result so a read in the completion cycle sees it
			adc_out_next = adc_done ? adc_result : adc_hold_reg; // [R11]
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || soft_rst) begin
			state_reg <= ATS_IDLE;
			task_reg <= '0;
			pc_reg <= RST_VECT;
			bg_act_reg <= 1'b0;
			bg_susp_reg <= 1'b0;
			noint_reg <= 1'b0;
			bg_ret_reg <= RST_VECT;
			pend_reg <= '0;
			start_reg <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			task_reg <= task_next;
			pc_reg <= pc_next;
			bg_act_reg <= bg_act_next;
			bg_susp_reg <= bg_susp_next;
			noint_reg <= noint_next;
			bg_ret_reg <= bg_ret_next;
			pend_reg <= pend_next;
			start_reg <= start_next;
			active_reg <= active_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bg_en_reg <= 1'b0;
			bg_vec_reg <= RST_VECT;
			ten_reg <= RST_TASK_EN;
			sh_reg <= RST_RAM_SHARED;
			prog_reg <= RST_RAM_PROG;
			for (int t = 0; t < TASKS; t++) begin
				sel_reg[t] <= '0;
			end
			rdata_reg <= '0;
			rd_vec_reg <= 1'b0;
			adc_hold_reg <= '0;
			adc_out_reg <= '0;
		end else begin
			bg_en_reg <= bg_en_next;
			bg_vec_reg <= bg_vec_next;
			ten_reg <= ten_next;
			sh_reg <= sh_next;
			prog_reg <= prog_next;
			sel_reg <= sel_next;
			rdata_reg <= rdata_next;
			rd_vec_reg <= rd_vec_next;
			adc_hold_reg <= adc_hold_next;
			adc_out_reg <= adc_out_next;
		end
	end

	// Vector words come from the store's own read register
	assign reg_rdata = rd_vec_reg ? {16'h0000, vmem.a_data} : rdata_reg;
	assign adc_rdata = adc_out_reg;
	assign accel_program_counter = pc_reg;
	assign task_start = start_reg;
	assign task_active = active_reg;
	assign task_num = task_reg;
	assign bg_running = bg_act_reg;
	assign ram_shared = sh_reg;
	assign ram_prog = prog_reg;
endmodule : ats_sched

//--- tb/ats_sched_asserts.sv
/*
 * Port-level assertions on the accelerator task scheduler.
 * Assumes it is bound to ats_sched and sees only its ports.
 */
module ats_sched_asserts
	import ats_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ATS_AW-1:0] reg_addr,
	input wire logic [ATS_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic core_step,
	input wire logic core_branch,
	input wire logic [ATS_PC_W-1:0] core_target,
	input wire logic adc_done,
	input wire logic [ATS_ADC_W-1:0] adc_result,
	input wire logic adc_rd,
	input wire logic [ATS_ADC_W-1:0] adc_rdata,
	input wire logic [ATS_PC_W-1:0] accel_program_counter,
	input wire logic task_start,
	input wire logic task_active,
	input wire logic [ATS_TID_W-1:0] task_num,
	input wire logic bg_running,
	input wire logic [ATS_RAM_N-1:0] ram_shared,
	input wire logic [ATS_RAM_N-1:0] ram_prog
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// Shadow of the enable bit
	// ********************
	logic bg_en_reg;
	logic bg_en_next;
	always_comb begin
		bg_en_next = bg_en_reg;
		if (reg_wr && reg_addr == OFS_BG_CTRL) begin
			bg_en_next = reg_wdata[BIT_BG_EN];
		end
	end
	always_ff @(posedge mclk) begin
		bg_en_reg <= rst_n ? bg_en_next : 1'b0;
	end
	// ********************
	// Properties
	// ********************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_START_PULSE: assert property (task_start |=> !task_start)
		else $error("task start longer than one cycle");
	AST_START_DISPATCH: assert property (task_start |-> task_active && !$past(task_active))
		else $error("task start without dispatch cycle");
	AST_PC_STEP: assert property (core_step && !core_branch && task_active
		|=> accel_program_counter == $past(accel_program_counter) + 16'h0001)
		else $error("program counter did not step");
	AST_PC_BRANCH: assert property (core_branch && task_active
		|=> accel_program_counter == $past(core_target))
		else $error("program counter missed branch target");
	AST_BG_TASK8: assert property ($rose(bg_running)
		|-> ##[0:1] (task_active && task_num == BG_TASK))
		else $error("background not on the lowest task");
	AST_BG_ENABLE: assert property ($rose(bg_running) |-> bg_en_reg)
		else $error("background without enable");
	AST_RAM_CFG: assert property (reg_wr && reg_addr == OFS_RAM_CFG
		|=> ram_shared == $past(reg_wdata[7:0]) && ram_prog == $past(reg_wdata[15:8]))
		else $error("shared ram setup not applied");
	AST_ADC_SAME: assert property (adc_rd && adc_done |=> adc_rdata == $past(adc_result))
		else $error("adc result of completion cycle lost");
	COV_START: cover property (task_start);
	COV_BG: cover property ($rose(bg_running));
	COV_ADC: cover property (adc_rd && adc_done);
endmodule : ats_sched_asserts

bind ats_sched ats_sched_asserts u_ats_sched_asserts (.*);

//--- tb/ats_src_model.sv
/*
 * Peripheral trigger sources facing the scheduler.
 * Assumes the bench asks for sources by a one-cycle mask on req.
 */
module ats_src_model
	import ats_pkg::*;
#(
	parameter int HOLD = 3
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ATS_SRC_N-1:0] req,
	output logic [ATS_SRC_N-1:0] periph_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Sources are levels that fall back to idle low after HOLD cycles
	always @(posedge mclk) begin
		if (!rst_n) begin
			periph_irq <= '0;
			cnt <= 0;
		end else if (req !== '0) begin
			periph_irq <= req;
			cnt <= HOLD;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else begin
			periph_irq <= '0;
			cnt <= 0;
		end
	end
endmodule : ats_src_model

//--- tb/ats_sched_test.sv
/*
 * Self-checking bench of the accelerator task scheduler.
 * Assumes a 100 MHz mclk and the plain strobe register bus.
 */
module ats_sched_test
	import ats_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [ATS_AW-1:0] reg_addr = '0;
	logic [ATS_DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic core_step = 1'b0;
	logic core_branch = 1'b0;
	logic core_task_end = 1'b0;
	logic core_bg_stop = 1'b0;
	logic core_noint_set = 1'b0;
	logic core_noint_clr = 1'b0;
	logic [ATS_PC_W-1:0] core_target = '0;
	logic adc_done = 1'b0;
	logic adc_rd = 1'b0;
	logic [ATS_ADC_W-1:0] adc_result = '0;
	logic [ATS_SRC_N-1:0] req = '0;
	logic [ATS_SRC_N-1:0] periph_irq;
	logic [ATS_DW-1:0] reg_rdata;
	logic [ATS_ADC_W-1:0] adc_rdata;
	logic [ATS_PC_W-1:0] accel_program_counter;
	logic task_start;
	logic task_active;
	logic [ATS_TID_W-1:0] task_num;
	logic bg_running;
	logic [ATS_RAM_N-1:0] ram_shared;
	logic [ATS_RAM_N-1:0] ram_prog;
	logic [15:0] vec [8];
	int sel [8];
	logic [15:0] bgv;
	logic [31:0] v;
	logic [31:0] exp_q [$];
	logic [31:0] adc_q [$];
	logic rd_d = 1'b0;
	logic adc_d = 1'b0;
	int n_mismatch = 0;
	int cmp_count = 0;
	ats_sched u_ats_sched (.*);
	ats_src_model u_ats_src_model (.*);
	initial begin
		forever #5 mclk = ~mclk;
	end
	// ********************
	// Tasks
	// ********************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd
	// Order: step, branch, end, stop, noint set, noint clear
	task core(input logic [5:0] c);
		@(posedge mclk);
		{core_step, core_branch, core_task_end, core_bg_stop, core_noint_set, core_noint_clr} <= c;
		@(posedge mclk);
		{core_step, core_branch, core_task_end, core_bg_stop, core_noint_set, core_noint_clr} <= 6'h00;
	endtask : core
	task fire(input logic [ATS_SRC_N-1:0] m);
		@(posedge mclk);
		req <= m;
		@(posedge mclk);
		req <= '0;
	endtask : fire
	function automatic logic [ATS_SRC_N-1:0] src_bit(input int i);
		return {{(ATS_SRC_N-1){1'b0}}, 1'b1} << sel[i];
	endfunction : src_bit
	// Waits for task t to be running, then checks its first cycle
	task wait_run(input logic [2:0] t, input logic [15:0] pc, input logic st);
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (task_active === 1'b1 && task_num === t) break;
		end
		chk("task_num", {29'h0, t}, {29'h0, task_num});
		chk("pc", {16'h0, pc}, {16'h0, accel_program_counter});
		chk("task_start", {31'h0, st}, {31'h0, task_start});
	endtask : wait_run
	// ********************
	// Result watcher
	// ********************
	always @(posedge mclk) begin
		rd_d <= reg_rd;
		adc_d <= adc_rd;
		if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
		if (adc_d) chk("adc_rdata", adc_q.pop_front(), {16'h0, adc_rdata});
	end
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	// ********************
	// Main sequence
	// ********************
	initial begin
		v = $urandom(32'he309);
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(OFS_TASK_EN, {24'h0, RST_TASK_EN});
		rd(OFS_PC, 32'h0);
		rd(8'hFC, 32'h0);
		v = $urandom() & 32'h0000FFFF;
		wr(OFS_RAM_CFG, v);
		rd(OFS_RAM_CFG, v);
		chk("ram", v, {16'h0, ram_prog, ram_shared});
		for (int i = 0; i < 8; i++) begin
			vec[i] = 16'($urandom());
			sel[i] = (i == 7) ? 255 : 36 * i;
			wr(OFS_VECT_BASE + 8'(4 * i), {16'h0, vec[i]});
			wr(OFS_SEL_BASE + 8'(4 * i), 32'(sel[i]));
		end
		wr(OFS_TASK_EN, 32'h000000FF);
		fire(src_bit(3));
		wait_run(3'd3, vec[3], 1'b1);
		core(6'h08);
		fire(src_bit(5) | src_bit(2));
		wait_run(3'd2, vec[2], 1'b1);
		core(6'h08);
		wait_run(3'd5, vec[5], 1'b1);
		core(6'h08);
		fire(src_bit(7));
		wait_run(3'd7, vec[7], 1'b1);
		core(6'h08);
		bgv = 16'($urandom());
		wr(OFS_BG_VECT, {16'h0, bgv});
		wr(OFS_BG_CTRL, 32'h00000001);
		fire(src_bit(7));
		wait_run(3'd7, bgv, 1'b1);
		chk("bg_running", 32'h1, {31'h0, bg_running});
		core_target <= 16'hFFFF;
		core(6'h10);
		core(6'h20);
		core(6'h20);
		rd(OFS_PC, 32'h00000001);
		fire(src_bit(0));
		wait_run(3'd0, vec[0], 1'b1);
		rd(OFS_BG_RET, 32'h00000001);
		core(6'h08);
		wait_run(3'd7, 16'h0001, 1'b0);
		core(6'h02);
		fire(src_bit(1));
		repeat (12) @(posedge mclk);
		chk("task_num", 32'h7, {29'h0, task_num});
		core(6'h01);
		wait_run(3'd1, vec[1], 1'b1);
		core(6'h08);
		wait_run(3'd7, 16'h0001, 1'b0);
		core(6'h04);
		repeat (3) @(posedge mclk);
		chk("task_active", 32'h0, {31'h0, task_active});
		rd(OFS_VECT_BASE + 8'h0C, {16'h0, vec[3]});
		rd(OFS_SEL_BASE + 8'h08, 32'(sel[2]));
		fire(src_bit(7));
		wait_run(3'd7, bgv, 1'b1);
		rd(OFS_STATUS, 32'h00000073);
		// Host kill ends the background task at once
		wr(OFS_BG_CTRL, 32'h00000003);
		repeat (2) @(posedge mclk);
		chk("bg_running", 32'h0, {31'h0, bg_running});
		chk("task_active", 32'h0, {31'h0, task_active});
		wr(OFS_BG_CTRL, 32'h00000005);
		rd(OFS_PC, 32'h0);
		rd(OFS_STATUS, 32'h0);
		@(posedge mclk);
		v = $urandom() & 32'h0000FFFF;
		adc_result <= v[15:0];
		adc_done <= 1'b1;
		adc_rd <= 1'b1;
		adc_q.push_back(v);
		@(posedge mclk);
		adc_done <= 1'b0;
		adc_rd <= 1'b0;
		repeat (3) @(posedge mclk);
		end_of_test();
	end
endmodule : ats_sched_test
